// ---- include/acc_map.svh ----
// Purpose: register offsets, field positions and reset values of the comparator control
// Assumes: byte-wide register port with a four-bit address
// Notes:   definitions only; included by bare name
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// register offsets
`define ACC_ADDR_CSR      4'h0
`define ACC_ADDR_NEGCFG   4'h1
`define ACC_ADDR_INTSTAT  4'h2
`define ACC_ADDR_INTMASK  4'h3

// control/status field positions
`define ACC_BIT_OFF       7
`define ACC_BIT_BANDGAP   6
`define ACC_BIT_RESULT    5
`define ACC_BIT_FLAG      4
`define ACC_BIT_IRQ_EN    3
`define ACC_BIT_CAPTURE   2
`define ACC_BIT_MODE_HI   1
`define ACC_BIT_MODE_LO   0

// negative input configuration field
`define ACC_BIT_NEG_MUX   0

// interrupt status and mask fields
`define ACC_IST_MATCH     0
`define ACC_IST_TOGGLE    1
`define ACC_IST_WIDTH     2

// reset values and idle read value
`define ACC_RST_BYTE      8'h00
`define ACC_RST_IST       2'h0
`define ACC_RD_IDLE       8'h00

`endif

// ---- include/acc_pkg.sv ----
// Purpose: types shared by the comparator control files
// Assumes: acc_map.svh holds the register numbers; the mode encodings stand here
// Notes:   nothing here is imported; users write acc_pkg::name
package acc_pkg;

   // event mode select encodings
   typedef enum logic [1:0] {
      ACC_MODE_TOGGLE   = 2'h0,
      ACC_MODE_RESERVED = 2'h1,
      ACC_MODE_FALL     = 2'h2,
      ACC_MODE_RISE     = 2'h3
   } acc_mode_t;

   // software-written control fields of the control/status register
   typedef struct packed {
      logic      comparator_off;
      logic      bandgap_select;
      logic      comparator_irq_enable;
      logic      capture_route_enable;
      acc_mode_t event_mode;
   } acc_ctrl_t;

   // selection handed to the analog multiplexers
   typedef struct packed {
      logic       bandgap_select;
      logic       use_channel;
      logic [2:0] channel;
   } acc_insel_t;

endpackage : acc_pkg

// ---- rtl/acc_sync.sv ----
// Purpose: two-stage synchroniser for the raw comparator decision
// Assumes: input changes without regard to the system clock
// Notes:   first stage feeds only the second stage
module acc_sync (
   input  wire logic clk,      // system clock
   input  wire logic rst,      // synchronous reset, active high
   input  wire logic din,      // asynchronous level
   output logic      dout      // synchronised level
);

   logic meta;
   logic next_meta;
   logic next_dout;

   // next values: plain shift by one stage
   always_comb begin
      next_meta = din;
      next_dout = meta;
   end

   // both stages clear at reset, so a high input after release shows as a rise
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end

endmodule // acc_sync

// ---- rtl/acc_ctrl.sv ----
// Purpose: control and status logic around an on-chip analog comparator
// Assumes: COMP_RAW is the analog decision, asynchronous to CLK_SYS
// Notes:   register port answers reads in the following cycle, no wait states
//          offsets 0x0..0x3; interrupt status and mask share one two-bit layout
//          mode or off-bit changes with the enable set may raise the flag;
//          software clears the enable first, the logic does not guard it
//          a set event beats a clear that lands in the same cycle
//          selection outputs lag their controls and inputs by one clock
//          the result bit reads as driven by hardware only
//          no wait states, so the master never stalls on this block
//
// Functional notes
// - raw decision high when positive exceeds negative
// - result bit synchronised, one to two cycles
// - off bit 7 powers comparator down
// - bit 6 selects bandgap for positive input
// - event flag bit 4 set on matching edge
// - interrupt needs flag, enable and global enable
// - flag cleared when interrupt vector executes
// - writing one clears flag, zero keeps
// - enable bit 3 gates the comparator interrupt
// - route bit 2 feeds timer capture input
// - route bit clear disconnects capture input
// - modes: 00 toggle, 10 fall, 11 rise
// - mux enable, converter off: channel selects negative
// - otherwise dedicated pin drives negative input
`include "acc_map.svh"

module acc_ctrl (
   // clock, reset and register port
   input  wire logic       CLK_SYS,          // system clock, 20 MHz
   input  wire logic       RST,              // synchronous reset, active high
   input  wire logic [3:0] ADDR,             // register address
   input  wire logic [7:0] WDATA,            // write data
   input  wire logic       WR,               // write strobe, one cycle
   input  wire logic       RD,               // read strobe, one cycle
   output logic      [7:0] RDATA,            // read data, cycle after RD
   // comparator decision and neighbouring blocks
   input  wire logic       COMP_RAW,         // analog decision from comparator
   input  wire logic       GLOBAL_IRQ_EN,    // global enable from processor status
   input  wire logic       VECTOR_ACK,       // pulse: comparator vector taken
   input  wire logic       CONV_ENABLE,      // converter enable level
   input  wire logic [2:0] CONV_CHANNEL,     // converter channel select
   // analog selection, capture feed and requests
   output logic            COMP_OFF,         // comparator power down
   output logic            POS_BANDGAP,      // positive input from bandgap
   output logic            NEG_USE_CHANNEL,  // negative input from converter mux
   output logic      [2:0] NEG_CHANNEL,      // converter channel for negative input
   output logic            CAPTURE_IN,       // comparator result to timer capture
   output logic            COMP_IRQ,         // comparator interrupt request
   output logic            INT               // level interrupt from status/mask
);

   // software control state
   acc_pkg::acc_ctrl_t  ctrl;
   acc_pkg::acc_ctrl_t  next_ctrl;
   logic                neg_mux_enable;
   logic                next_neg_mux_enable;
   logic [`ACC_IST_WIDTH-1:0] int_mask;
   logic [`ACC_IST_WIDTH-1:0] next_int_mask;

   // event state
   logic                result;
   logic                result_prev;
   logic                next_result_prev;
   logic                flag;
   logic                next_flag;
   logic [`ACC_IST_WIDTH-1:0] int_stat;
   logic [`ACC_IST_WIDTH-1:0] next_int_stat;

   // output state
   acc_pkg::acc_insel_t insel;
   acc_pkg::acc_insel_t next_insel;
   logic [7:0]          next_rdata;
   logic                next_comp_off;
   logic                next_capture_in;
   logic                next_comp_irq;
   logic                next_int;

   // decoded strobes and edges
   logic                wr_csr;
   logic                wr_negcfg;
   logic                wr_intmask;
   logic                rd_intstat;
   logic                rise;
   logic                fall;
   logic                toggle;
   logic                match;
   logic [7:0]          csr_view;
   logic [`ACC_IST_WIDTH-1:0] events;

   // the analog decision arrives unsynchronised; two flops before any use
   // a single flop here could hand metastable levels to the edge logic
   acc_sync u_sync (
      .clk  (CLK_SYS),
      .rst  (RST),
      .din  (COMP_RAW),
      .dout (result)
   );

   // address decode of the register port
   // unmapped addresses decode to no strobe, so writes there are lost
   always_comb begin
      wr_csr     = WR && (ADDR == `ACC_ADDR_CSR);
      wr_negcfg  = WR && (ADDR == `ACC_ADDR_NEGCFG);
      wr_intmask = WR && (ADDR == `ACC_ADDR_INTMASK);
      rd_intstat = RD && (ADDR == `ACC_ADDR_INTSTAT);
   end

   // edges of the synchronised result; prev flop is past the synchroniser
   // edges are taken on synchronised levels only, never on the raw input
   always_comb begin
      rise   = result && !result_prev;
      fall   = !result && result_prev;
      toggle = rise || fall;
   end

   // event kind chosen by the mode bits; reserved code never fires
   // the toggle status bit still counts edges under the reserved code
   always_comb begin
      unique case (ctrl.event_mode)
         acc_pkg::ACC_MODE_TOGGLE:   match = toggle;
         acc_pkg::ACC_MODE_FALL:     match = fall;
         acc_pkg::ACC_MODE_RISE:     match = rise;
         acc_pkg::ACC_MODE_RESERVED: match = 1'b0;
      endcase
   end

   // events gathered for the sticky status register
   // match follows the mode; toggle counts every edge of the result
   always_comb begin
      events                  = '0;
      events[`ACC_IST_MATCH]  = match;
      events[`ACC_IST_TOGGLE] = toggle;
   end

   // control fields; mode changes with the enable set may fire, software's care
   // the result bit position is dropped here, so software cannot write it
   always_comb begin
      next_ctrl           = ctrl;
      next_neg_mux_enable = neg_mux_enable;
      next_int_mask       = int_mask;
      if (wr_csr) begin
         next_ctrl.comparator_off        = WDATA[`ACC_BIT_OFF];
         next_ctrl.bandgap_select        = WDATA[`ACC_BIT_BANDGAP];
         next_ctrl.comparator_irq_enable = WDATA[`ACC_BIT_IRQ_EN];
         next_ctrl.capture_route_enable  = WDATA[`ACC_BIT_CAPTURE];
         next_ctrl.event_mode            = acc_pkg::acc_mode_t'(
            {WDATA[`ACC_BIT_MODE_HI], WDATA[`ACC_BIT_MODE_LO]});
      end
      if (wr_negcfg) begin
         next_neg_mux_enable = WDATA[`ACC_BIT_NEG_MUX];
      end
      if (wr_intmask) begin
         next_int_mask = WDATA[`ACC_IST_WIDTH-1:0];
      end
   end

   // control registers, all zero after reset
   // the reserved mode code is stored as written and reads back unchanged
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ctrl           <= '0;
         neg_mux_enable <= 1'b0;
         int_mask       <= `ACC_RST_IST;
      end else begin
         ctrl           <= next_ctrl;
         neg_mux_enable <= next_neg_mux_enable;
         int_mask       <= next_int_mask;
      end
   end

   // event flag: a new event wins over a clear in the same cycle
   // losing the event would drop an interrupt that software never sees
   // vector clear and software clear act alike
   always_comb begin
      next_flag = flag;
      if (VECTOR_ACK) begin
         next_flag = 1'b0;
      end
      if (wr_csr && WDATA[`ACC_BIT_FLAG]) begin
         next_flag = 1'b0;
      end
      if (match) begin
         next_flag = 1'b1;
      end
   end

   // sticky status: read clears, events landing in that cycle survive
   // the previous result is registered here too, for the edge logic
   always_comb begin
      next_int_stat = int_stat;
      if (rd_intstat) begin
         next_int_stat = '0;
      end
      next_int_stat = next_int_stat | events;
      next_result_prev = result;
   end

   // event registers
   // synchroniser and edge flop reset low, so a high input shows as a rise
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         flag        <= 1'b0;
         int_stat    <= `ACC_RST_IST;
         result_prev <= 1'b0;
      end else begin
         flag        <= next_flag;
         int_stat    <= next_int_stat;
         result_prev <= next_result_prev;
      end
   end

   // analog input selection
   // the converter must be off before its mux may feed the comparator
   // the channel reads zero whenever the negative pin is in use
   always_comb begin
      next_insel.bandgap_select = ctrl.bandgap_select;
      next_insel.use_channel    = neg_mux_enable && !CONV_ENABLE;
      next_insel.channel        = next_insel.use_channel ? CONV_CHANNEL : 3'h0;
      next_comp_off             = ctrl.comparator_off;
   end

   // capture path: held low when not routed, so the timer sees no edge
   // the timer's own noise filter and edge select act on this level
   always_comb begin
      next_capture_in = ctrl.capture_route_enable && result;
   end

   // interrupt outputs; the vector clear takes one cycle to reach COMP_IRQ
   // both are computed from next values so they rise with the flag or bit
   // global enable comes from the processor status, sampled each clock
   always_comb begin
      next_comp_irq = next_flag && ctrl.comparator_irq_enable
                      && GLOBAL_IRQ_EN;
      next_int      = |(next_int_stat & int_mask);
   end

   // view of the control/status register; result bit comes from hardware
   // the flag reads back as stored, not gated by the enable
   always_comb begin
      csr_view                   = `ACC_RST_BYTE;
      csr_view[`ACC_BIT_OFF]     = ctrl.comparator_off;
      csr_view[`ACC_BIT_BANDGAP] = ctrl.bandgap_select;
      csr_view[`ACC_BIT_RESULT]  = result;
      csr_view[`ACC_BIT_FLAG]    = flag;
      csr_view[`ACC_BIT_IRQ_EN]  = ctrl.comparator_irq_enable;
      csr_view[`ACC_BIT_CAPTURE] = ctrl.capture_route_enable;
      csr_view[`ACC_BIT_MODE_HI] = ctrl.event_mode[1];
      csr_view[`ACC_BIT_MODE_LO] = ctrl.event_mode[0];
   end

   // read mux; unmapped addresses and idle cycles read zero
   // read data stand one cycle only, then fall back to zero
   always_comb begin
      next_rdata = `ACC_RD_IDLE;
      if (RD) begin
         unique case (ADDR)
            `ACC_ADDR_CSR:     next_rdata = csr_view;
            `ACC_ADDR_NEGCFG:  next_rdata = {7'h00, neg_mux_enable};
            `ACC_ADDR_INTSTAT: next_rdata = {6'h00, int_stat};
            `ACC_ADDR_INTMASK: next_rdata = {6'h00, int_mask};
            default:           next_rdata = `ACC_RD_IDLE;
         endcase
      end
   end

   // every output leaves from a flop
   // so no decode glitch reaches the analog side or the interrupt lines
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RDATA           <= `ACC_RD_IDLE;
         insel           <= '0;
         COMP_OFF        <= 1'b0;
         CAPTURE_IN      <= 1'b0;
         COMP_IRQ        <= 1'b0;
         INT             <= 1'b0;
      end else begin
         RDATA           <= next_rdata;
         insel           <= next_insel;
         COMP_OFF        <= next_comp_off;
         CAPTURE_IN      <= next_capture_in;
         COMP_IRQ        <= next_comp_irq;
         INT             <= next_int;
      end
   end

   // struct fields onto the selection ports
   // plain wiring from the registered selection, no logic here
   always_comb begin
      POS_BANDGAP     = insel.bandgap_select;
      NEG_USE_CHANNEL = insel.use_channel;
      NEG_CHANNEL     = insel.channel;
   end

endmodule // acc_ctrl

// ---- sim/acc_comparator_model.sv ----
// Purpose: behavioural comparator with its input selection
// Assumes: levels in millivolts
// Notes:   a powered-down comparator decides low
module acc_comparator_model #(
   parameter int BANDGAP_MV = 1100      // plain default reference
) (
   input  wire logic       off,         // power down
   input  wire logic       bandgap,     // positive from reference
   input  wire logic       use_chan,    // negative from converter mux
   input  wire logic [2:0] chan,        // converter channel
   input  var  int         pos_mv,      // positive pin
   input  var  int         neg_mv,      // negative pin
   input  var  int         chan_mv [8], // converter inputs
   output logic            raw          // decision
);
   timeunit 1ns;
   timeprecision 1ns;
   int p_mv;
   int n_mv;
   // select both inputs, then compare
   always_comb begin
      p_mv = bandgap ? BANDGAP_MV : pos_mv;
      n_mv = use_chan ? chan_mv[chan] : neg_mv;
      raw = !off && (p_mv > n_mv);
   end
endmodule // acc_comparator_model

// ---- sim/acc_ctrl_assertions.sv ----
// Purpose: port checks of the comparator control
// Assumes: an edge of COMP_RAW reaches the flags three edges on
// Notes:   bound after the module
module acc_ctrl_assertions (
   input wire logic       CLK_SYS,         // clock
   input wire logic       RST,             // reset
   input wire logic [3:0] ADDR,            // address
   input wire logic       WR,              // write strobe
   input wire logic       RD,              // read strobe
   input wire logic [7:0] RDATA,           // read data
   input wire logic       COMP_RAW,        // decision
   input wire logic       GLOBAL_IRQ_EN,   // global enable
   input wire logic       VECTOR_ACK,      // vector taken
   input wire logic       CONV_ENABLE,     // converter on
   input wire logic [2:0] CONV_CHANNEL,    // converter channel
   input wire logic       NEG_USE_CHANNEL, // negative from mux
   input wire logic [2:0] NEG_CHANNEL,     // negative channel
   input wire logic       CAPTURE_IN,      // capture feed
   input wire logic       COMP_IRQ,        // comparator irq
   input wire logic       INT              // status irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // no decision edge reaches the flags at this edge
   sequence quiet_s;
      $past(COMP_RAW, 2) == $past(COMP_RAW, 3);
   endsequence
   // read taken at one address
   sequence read_s(a);
      RD && ADDR == a;
   endsequence
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not idle");
   result_read_a: assert property (
      read_s(4'h0) ##0 $past(COMP_RAW) == $past(COMP_RAW, 2) |=> RDATA[5] == $past(COMP_RAW, 3))
      else $error("result bit wrong");
   neg_conv_a: assert property (NEG_USE_CHANNEL |-> !$past(CONV_ENABLE))
      else $error("mux used while converter on");
   neg_chan_a: assert property (
      NEG_CHANNEL == (NEG_USE_CHANNEL ? $past(CONV_CHANNEL) : 3'h0))
      else $error("negative channel wrong");
   irq_global_a: assert property (COMP_IRQ |-> $past(GLOBAL_IRQ_EN))
      else $error("irq without global enable");
   irq_hold_a: assert property (
      COMP_IRQ && GLOBAL_IRQ_EN && !VECTOR_ACK && !WR && !$past(WR) |=> COMP_IRQ)
      else $error("irq dropped by itself");
   capture_route_a: assert property (CAPTURE_IN |-> $past(COMP_RAW, 3))
      else $error("capture without result");
   vector_clear_a: assert property (VECTOR_ACK ##0 quiet_s |=> !COMP_IRQ)
      else $error("flag kept after vector");
   status_clear_a: assert property (read_s(4'h2) ##0 quiet_s |=> !INT)
      else $error("status kept after read");
endmodule // acc_ctrl_assertions
bind acc_ctrl acc_ctrl_assertions i_chk (.CLK_SYS, .RST, .ADDR, .WR, .RD, .RDATA, .COMP_RAW,
   .GLOBAL_IRQ_EN, .VECTOR_ACK, .CONV_ENABLE, .CONV_CHANNEL, .NEG_USE_CHANNEL, .NEG_CHANNEL,
   .CAPTURE_IN, .COMP_IRQ, .INT);

// ---- sim/acc_ctrl_test.sv ----
// Purpose: self-checking bench for the comparator control
// Assumes: model turns pos_mv into COMP_RAW against 1000 mV
// Notes:   table covers event modes, hand tests the rest
module acc_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [1:0] mode; // event mode
      logic       rise; // final level
      logic [7:0] exp;  // expected csr
   } acc_row_t;
   logic       CLK_SYS = 1'b0;
   logic       RST = 1'b1;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic       GLOBAL_IRQ_EN = 1'b0;
   logic       VECTOR_ACK = 1'b0;
   logic       CONV_ENABLE = 1'b0;
   logic [2:0] CONV_CHANNEL = 3'h0;
   logic [7:0] RDATA;
   logic [2:0] NEG_CHANNEL;
   logic       COMP_RAW, COMP_OFF, POS_BANDGAP, NEG_USE_CHANNEL, CAPTURE_IN, COMP_IRQ, INT;
   int         pos_mv = 0;
   int         chan_mv [8] = '{default: 0};
   int         error_cnt = 0;
   int         n_tests = 0;
   // every mode with both edges; reserved mode never flags
   acc_row_t   rows [8] = '{'{2'h0, 1'b1, 8'h30}, '{2'h0, 1'b0, 8'h10}, '{2'h1, 1'b1, 8'h21},
      '{2'h1, 1'b0, 8'h01}, '{2'h2, 1'b1, 8'h22}, '{2'h2, 1'b0, 8'h12},
      '{2'h3, 1'b1, 8'h33}, '{2'h3, 1'b0, 8'h03}};
   always #25 CLK_SYS = ~CLK_SYS;
   acc_ctrl i_dut (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .COMP_RAW, .GLOBAL_IRQ_EN,
      .VECTOR_ACK, .CONV_ENABLE, .CONV_CHANNEL, .COMP_OFF, .POS_BANDGAP, .NEG_USE_CHANNEL,
      .NEG_CHANNEL, .CAPTURE_IN, .COMP_IRQ, .INT);
   acc_comparator_model i_model (.off(COMP_OFF), .bandgap(POS_BANDGAP), .use_chan(NEG_USE_CHANNEL),
      .chan(NEG_CHANNEL), .pos_mv(pos_mv), .neg_mv(1000), .chan_mv(chan_mv), .raw(COMP_RAW));
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   // strobes rise after an edge and fall after the next one
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      @(negedge CLK_SYS);
      chk(nm, RDATA, exp);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask
   task automatic lvl(input int v);
      @(posedge CLK_SYS);
      pos_mv <= v;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // cut a hang short; the run needs under a thousand cycles
   initial begin
      repeat (3000) @(posedge CLK_SYS);
      error_cnt++;
      print_verdict();
   end
   // table first, then reset, interrupts, selection
   initial begin
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      foreach (rows[i]) begin
         wr(4'h0, {6'h00, rows[i].mode});
         lvl(rows[i].rise ? 0 : 2000);
         wt(5);
         wr(4'h0, {4'h1, 2'h0, rows[i].mode});
         lvl(rows[i].rise ? 2000 : 0);
         wt(5);
         rd(4'h0, rows[i].exp, "event");
      end
      $display("table done");
      @(posedge CLK_SYS);
      RST <= 1'b1;
      wt(2);
      @(posedge CLK_SYS);
      RST <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd(a[3:0], 8'h00, "reset");
      end
      $display("reset done");
      wr(4'h3, 8'h03);
      @(posedge CLK_SYS);
      GLOBAL_IRQ_EN <= 1'b1;
      wr(4'h0, 8'h0B);
      lvl(2000);
      wt(5);
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h03);
      rd(4'h2, 8'h03, "status");
      wt(1);
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h02);
      @(posedge CLK_SYS);
      VECTOR_ACK <= 1'b1;
      @(posedge CLK_SYS);
      VECTOR_ACK <= 1'b0;
      wt(1);
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h00);
      wr(4'h3, 8'h00);
      lvl(0);
      wt(5);
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h00);
      rd(4'h2, 8'h02, "status");
      wr(4'h0, 8'h03);
      wr(4'h0, 8'h08);
      @(posedge CLK_SYS);
      GLOBAL_IRQ_EN <= 1'b0;
      lvl(2000);
      wt(5);
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h00);
      @(posedge CLK_SYS);
      GLOBAL_IRQ_EN <= 1'b1;
      wt(2);
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h02);
      wr(4'h0, 8'h18);
      wt(2);
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h00);
      lvl(0);
      wt(5);
      $display("irq done");
      wr(4'h0, 8'h10);
      wr(4'h0, 8'hF4);
      rd(4'h0, 8'hC4, "csr");
      chk("sel", {6'h00, COMP_OFF, POS_BANDGAP}, 8'h03);
      wr(4'h0, 8'h44);
      wt(6);
      chk("capture", {7'h00, CAPTURE_IN}, 8'h01);
      rd(4'h0, 8'h74, "csr");
      chk("irq", {6'h00, COMP_IRQ, INT}, 8'h00);
      wr(4'h0, 8'h40);
      wt(2);
      chk("capture", {7'h00, CAPTURE_IN}, 8'h00);
      wr(4'h1, 8'h01);
      for (int c = 0; c < 8; c++) begin
         @(posedge CLK_SYS);
         CONV_CHANNEL <= c[2:0];
         wt(2);
         chk("negsel", {4'h0, NEG_USE_CHANNEL, NEG_CHANNEL}, {5'h01, c[2:0]});
      end
      @(posedge CLK_SYS);
      CONV_ENABLE <= 1'b1;
      wt(2);
      chk("negsel", {4'h0, NEG_USE_CHANNEL, NEG_CHANNEL}, 8'h00);
      $display("selection done");
      print_verdict();
   end
endmodule // acc_ctrl_test
